// ===== src/lpd_led_chan.sv
`timescale 1ns/1ps
module lpd_led_chan #(
  parameter bit BLINK = 1'b1,
  parameter bit FADE = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic restart,
  input wire logic period_end,
  input wire logic run,
  input wire lpd_pkg::lpd_byte_t ton,
  input wire lpd_pkg::lpd_byte_t ion,
  input wire lpd_pkg::lpd_byte_t off_set,
  input wire lpd_pkg::lpd_byte_t trise,
  input wire lpd_pkg::lpd_byte_t tfall,
  output lpd_pkg::lpd_byte_t level_q
);
  import lpd_pkg::*;

  lpd_phase_t phase_q;
  logic [4:0] timer_q;
  logic [4:0] fcnt_q;
  logic [4:0] on_t;
  logic [4:0] off_t;
  logic [4:0] ramp_t;
  lpd_byte_t off_lvl;
  lpd_byte_t tgt;

  assign on_t = BLINK ? ton[4:0] : 5'h0;
  assign off_t = BLINK ? off_set[7:3] : 5'h0;
  assign off_lvl = BLINK ? {off_set[2:0], 5'h00} : 8'h00;
  assign tgt = (phase_q == PH_RISE) ? ion : off_lvl;
  assign ramp_t = !FADE ? 5'h0 : (phase_q == PH_RISE) ? trise[4:0] : tfall[4:0];

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || restart) begin
      phase_q <= PH_IDLE;
      timer_q <= 5'h0;
    end else if (period_end) begin
      case (phase_q)
        PH_IDLE: if (run) phase_q <= PH_RISE;
        PH_RISE: begin
          if (!run) phase_q <= PH_FALL;
          else if (level_q == ion) begin
            phase_q <= PH_ON;
            timer_q <= 5'h0;
          end
        end
        PH_ON: begin
          if (!run) phase_q <= PH_FALL;
          else if (on_t != 5'h0) begin
            if (timer_q + 5'h1 >= on_t) begin
              phase_q <= PH_FALL;
              timer_q <= 5'h0;
            end else timer_q <= timer_q + 5'h1;
          end
        end
        PH_FALL: begin
          if (level_q == off_lvl) begin
            if (!run) phase_q <= PH_IDLE;
            else if (on_t == 5'h0) phase_q <= PH_RISE;
            else if (off_t == 5'h0) phase_q <= PH_DONE;
            else phase_q <= PH_OFF;
            timer_q <= 5'h0;
          end
        end
        PH_OFF: begin
          if (!run) phase_q <= PH_IDLE;
          else if (timer_q + 5'h1 >= off_t) begin
            phase_q <= PH_RISE;
            timer_q <= 5'h0;
          end else timer_q <= timer_q + 5'h1;
        end
        PH_DONE: if (!run) phase_q <= PH_IDLE;
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Intensity ramp
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      level_q <= 8'h00;
      fcnt_q <= 5'h0;
    end else if (restart) begin
      fcnt_q <= 5'h0;
    end else if (period_end) begin
      if (phase_q == PH_IDLE) level_q <= off_lvl;
      else if (phase_q == PH_RISE || phase_q == PH_FALL) begin
        if (ramp_t == 5'h0) level_q <= tgt;
        else if (fcnt_q >= ramp_t) begin
          fcnt_q <= 5'h0;
          if (level_q < tgt) level_q <= level_q + 8'h01;
          else if (level_q > tgt) level_q <= level_q - 8'h01;
        end else fcnt_q <= fcnt_q + 5'h1;
      end
    end
  end
endmodule : lpd_led_chan

// ===== src/lpd_led_driver.sv
`timescale 1ns/1ps
`include "lpd_map.svh"
// How it works
// - All pin drivers share one LED clock chosen by misc bits 6 to 4.
// - The shared LED clock is off after reset.
// - A pin driver runs only with LED clock on and its enable bit set.
// - On time zero means static mode; pins without blink use zero off level.
// - Nonzero on time with zero off time runs a single shot.
// - Nonzero on and off times run continuous blinking.
// - Shot and blink exist on blink-capable pins only; static everywhere.
// - Pins without fade jump straight to the on or off level.
// - Each pin holds intensity, timing, off and fade settings by capability.
// - Fade-capable pins pick linear or logarithmic curve by one misc bit shared by all of them.
// - Logarithmic curve maps eight-bit level through fixed table.
// - Enabled external reset clears LED timing counters, keeps registers.
// - Clock register picks source, oscillator pin direction, output divider.
// - Oscillator pin serves as plain output when not used for the clock.
// - The main oscillator clock times the LED drivers.
// - With driver enabled, data high keeps LED off, data low starts it.
// - Each pin polarity inverts by its polarity register bit, except while LED clock is on and its enable bit set.
module lpd_led_driver (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic oscillator_input,
  output logic oscillator_output,
  output logic oscillator_oe,
  input wire logic external_reset_pin_n
);
  import lpd_pkg::*;

  localparam int NPIN = 4;
  localparam logic [6:0] INT_DIV_LAST = 7'(`LPD_INT_OSC_DIV - 1);
  localparam lpd_byte_t LOG_TBL [128] = '{
    8'd0, 8'd0, 8'd0, 8'd0, 8'd1, 8'd1, 8'd1, 8'd1, 8'd2, 8'd2, 8'd2, 8'd2, 8'd3, 8'd3, 8'd3, 8'd3,
    8'd4, 8'd4, 8'd5, 8'd5, 8'd6, 8'd6, 8'd7, 8'd7, 8'd8, 8'd8, 8'd9, 8'd9, 8'd10, 8'd10, 8'd11, 8'd12,
    8'd13, 8'd13, 8'd14, 8'd14, 8'd16, 8'd17, 8'd18, 8'd19, 8'd20, 8'd21, 8'd22, 8'd23, 8'd24, 8'd25,
    8'd26, 8'd27, 8'd28, 8'd30, 8'd31, 8'd32, 8'd34, 8'd35, 8'd36, 8'd38, 8'd39, 8'd41, 8'd42, 8'd44,
    8'd46, 8'd46, 8'd49, 8'd49, 8'd53, 8'd53, 8'd56, 8'd56, 8'd60, 8'd60, 8'd65, 8'd65, 8'd69, 8'd69,
    8'd73, 8'd73, 8'd78, 8'd78, 8'd83, 8'd83, 8'd88, 8'd88, 8'd93, 8'd93, 8'd98, 8'd98, 8'd104, 8'd104,
    8'd110, 8'd110, 8'd116, 8'd116, 8'd122, 8'd122, 8'd129, 8'd129, 8'd135, 8'd135, 8'd142, 8'd142,
    8'd150, 8'd150, 8'd157, 8'd157, 8'd165, 8'd165, 8'd172, 8'd172, 8'd181, 8'd181, 8'd189, 8'd189,
    8'd198, 8'd198, 8'd207, 8'd207, 8'd216, 8'd216, 8'd225, 8'd225, 8'd235, 8'd235, 8'd245, 8'd245,
    8'd255, 8'd255, 8'd255, 8'd255
  };

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0] inbuf_off_q;
  logic [3:0] open_drain_q;
  logic [3:0] polarity_q;
  logic [3:0] direction_q;
  logic [3:0] data_q;
  lpd_byte_t clock_cfg_q;
  lpd_byte_t misc_q;
  logic [3:0] led_en_q;
  lpd_byte_t ton_q [NPIN];
  lpd_byte_t ion_q [NPIN];
  lpd_byte_t off_q [NPIN];
  lpd_byte_t trise_q [NPIN];
  lpd_byte_t tfall_q [NPIN];

  // Bus state
  logic wr_q;
  logic rd_q;
  logic map_ok_q;
  logic [7:0] idx_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic accept;
  lpd_byte_t wd;
  lpd_byte_t rmux;

  // Synchronisers and clocking
  logic [3:0] io_s1_q;
  logic [3:0] io_s2_q;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic nrst_s1_q;
  logic nrst_s2_q;
  logic [6:0] int_cnt_q;
  logic [6:0] shared_led_clock_cnt_q;
  logic [14:0] osc_cnt_q;
  logic osc_tgl_q;
  logic oscillator_output_q;
  logic oscillator_oe_q;
  logic main_osc_clock_tick;
  logic main_osc_clock_on;
  logic shared_led_clock_on;
  logic shared_led_clock_tick;
  logic sync_clr;
  logic [2:0] shared_led_clock_sel;
  logic [6:0] shared_led_clock_mask;
  logic [3:0] osc_code;
  logic [14:0] osc_limit;
  logic [7:0] pwm_cnt_q;
  logic period_end;
  logic [3:0] pwm_q;
  logic [3:0] io_out_q;
  logic [3:0] io_oe_q;
  lpd_byte_t level [NPIN];

  function automatic logic [7:0] pin_base(input int i);
    pin_base = (i == 0) ? `LPD_IDX_PIN0 : 8'(`LPD_IDX_PIN1 + `LPD_PIN_STRIDE * 8'(i - 1));
  endfunction : pin_base

  // ----------------------------------------------------------------
  // AHB-Lite slave: writes complete with no wait, reads with one wait
  // ----------------------------------------------------------------
  assign accept = hsel && htrans[1] && hready;
  assign wd = hwdata[7:0];

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      map_ok_q <= 1'b0;
      idx_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_q <= accept && hwrite;
      rd_q <= 1'b0;
      if (accept) begin
        idx_q <= haddr[9:2];
        map_ok_q <= (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
      end
      if (accept && !hwrite) begin
        // The wait lets a write in the preceding data phase land before the read mux is sampled
        rd_q <= 1'b1;
        hreadyout_q <= 1'b0;
      end else if (rd_q) begin
        hrdata_q <= {24'h00_0000, map_ok_q ? rmux : 8'h00};
        hreadyout_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rmux = 8'h00;
    if (idx_q == `LPD_IDX_INBUF_OFF) rmux = {4'h0, inbuf_off_q};
    else if (idx_q == `LPD_IDX_OPEN_DRAIN) rmux = {4'h0, open_drain_q};
    else if (idx_q == `LPD_IDX_POLARITY) rmux = {4'h0, polarity_q};
    else if (idx_q == `LPD_IDX_DIRECTION) rmux = {4'h0, direction_q};
    else if (idx_q == `LPD_IDX_DATA) rmux = {4'h0, (direction_q & ~inbuf_off_q & io_s2_q) | (~direction_q & data_q)};
    else if (idx_q == `LPD_IDX_CLOCK) rmux = clock_cfg_q;
    else if (idx_q == `LPD_IDX_MISC) rmux = misc_q;
    else if (idx_q == `LPD_IDX_LED_EN) rmux = {4'h0, led_en_q};
    else if (idx_q == `LPD_IDX_STATUS) rmux = {2'h0, main_osc_clock_on, shared_led_clock_on, pwm_q};
    for (int i = 0; i < NPIN; i++) begin
      if (idx_q == pin_base(i)) rmux = ton_q[i];
      if (idx_q == pin_base(i) + 8'h01) rmux = ion_q[i];
      if (idx_q == pin_base(i) + 8'h02) rmux = off_q[i];
      if (i != 0 && idx_q == pin_base(i) + 8'h03) rmux = trise_q[i];
      if (i != 0 && idx_q == pin_base(i) + 8'h04) rmux = tfall_q[i];
    end
  end

  // ----------------------------------------------------------------
  // Device configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      inbuf_off_q <= 4'h0;
      open_drain_q <= 4'h0;
      polarity_q <= 4'h0;
      direction_q <= `LPD_RST_DIR;
      data_q <= `LPD_RST_DATA;
      clock_cfg_q <= `LPD_RST_ZERO;
      misc_q <= `LPD_RST_ZERO;
      led_en_q <= 4'h0;
    end else if (wr_q && map_ok_q) begin
      if (idx_q == `LPD_IDX_INBUF_OFF) inbuf_off_q <= wd[3:0];
      else if (idx_q == `LPD_IDX_OPEN_DRAIN) open_drain_q <= wd[3:0];
      else if (idx_q == `LPD_IDX_POLARITY) polarity_q <= wd[3:0];
      else if (idx_q == `LPD_IDX_DIRECTION) direction_q <= wd[3:0];
      else if (idx_q == `LPD_IDX_DATA) data_q <= wd[3:0];
      else if (idx_q == `LPD_IDX_CLOCK) clock_cfg_q <= wd;
      else if (idx_q == `LPD_IDX_MISC) misc_q <= wd;
      else if (idx_q == `LPD_IDX_LED_EN) led_en_q <= wd[3:0];
    end
  end

  // Per-pin LED settings; pin 0 has no fade registers
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NPIN; i++) begin
        ton_q[i] <= `LPD_RST_ZERO;
        ion_q[i] <= `LPD_RST_ION;
        off_q[i] <= `LPD_RST_ZERO;
        trise_q[i] <= `LPD_RST_ZERO;
        tfall_q[i] <= `LPD_RST_ZERO;
      end
    end else if (wr_q && map_ok_q) begin
      for (int i = 0; i < NPIN; i++) begin
        if (idx_q == pin_base(i)) ton_q[i] <= wd;
        if (idx_q == pin_base(i) + 8'h01) ion_q[i] <= wd;
        if (idx_q == pin_base(i) + 8'h02) off_q[i] <= wd;
        if (i != 0 && idx_q == pin_base(i) + 8'h03) trise_q[i] <= wd;
        if (i != 0 && idx_q == pin_base(i) + 8'h04) tfall_q[i] <= wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      io_s1_q <= 4'h0;
      io_s2_q <= 4'h0;
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      nrst_s1_q <= 1'b1;
      nrst_s2_q <= 1'b1;
    end else begin
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
      osc_s1_q <= oscillator_input;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      nrst_s1_q <= external_reset_pin_n;
      nrst_s2_q <= nrst_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Main oscillator clock and shared LED clock
  // ----------------------------------------------------------------
  assign sync_clr = misc_q[`LPD_MISC_NRST_BIT] && !nrst_s2_q;
  assign main_osc_clock_on = (clock_cfg_q[`LPD_CLK_SRC_HI:`LPD_CLK_SRC_LO] == `LPD_SRC_INT) ||
                   (clock_cfg_q[`LPD_CLK_SRC_HI:`LPD_CLK_SRC_LO] == `LPD_SRC_EXT);

  always_comb begin
    main_osc_clock_tick = 1'b0;
    if (clock_cfg_q[`LPD_CLK_SRC_HI:`LPD_CLK_SRC_LO] == `LPD_SRC_INT) main_osc_clock_tick = (int_cnt_q == INT_DIV_LAST);
    else if (clock_cfg_q[`LPD_CLK_SRC_HI:`LPD_CLK_SRC_LO] == `LPD_SRC_EXT) main_osc_clock_tick = osc_s2_q && !osc_s3_q;
  end

  assign shared_led_clock_sel = misc_q[`LPD_MISC_SHARED_LED_CLOCK_HI:`LPD_MISC_SHARED_LED_CLOCK_LO];
  assign shared_led_clock_mask = 7'((7'h01 << (shared_led_clock_sel - 3'h1)) - 7'h01);
  assign shared_led_clock_on = main_osc_clock_on && (shared_led_clock_sel != 3'h0);
  assign shared_led_clock_tick = shared_led_clock_on && main_osc_clock_tick && ((shared_led_clock_cnt_q & shared_led_clock_mask) == shared_led_clock_mask);

  // Counters clear while the enabled external reset is held low so a restart lines every chip up
  always_ff @(posedge clk) begin
    if (reset || sync_clr) begin
      int_cnt_q <= 7'h00;
      shared_led_clock_cnt_q <= 7'h00;
      pwm_cnt_q <= 8'h00;
    end else begin
      int_cnt_q <= (int_cnt_q == INT_DIV_LAST) ? 7'h00 : int_cnt_q + 7'h01;
      if (main_osc_clock_tick) shared_led_clock_cnt_q <= shared_led_clock_cnt_q + 7'h01;
      if (shared_led_clock_tick) pwm_cnt_q <= pwm_cnt_q + 8'h01;
    end
  end

  assign period_end = shared_led_clock_tick && (pwm_cnt_q == 8'hFF);

  // ----------------------------------------------------------------
  // Oscillator pin: clock out, clock in or plain output
  // ----------------------------------------------------------------
  assign osc_code = clock_cfg_q[3:0];
  assign osc_limit = 15'((15'h0001 << (osc_code - 4'h1)) - 15'h0001);

  always_ff @(posedge clk) begin
    if (reset || sync_clr) begin
      osc_cnt_q <= 15'h0000;
      osc_tgl_q <= 1'b0;
    end else if (main_osc_clock_tick) begin
      if (osc_cnt_q >= osc_limit) begin
        osc_cnt_q <= 15'h0000;
        osc_tgl_q <= !osc_tgl_q;
      end else osc_cnt_q <= osc_cnt_q + 15'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      oscillator_output_q <= 1'b0;
      oscillator_oe_q <= 1'b0;
    end else begin
      oscillator_oe_q <= clock_cfg_q[`LPD_CLK_PIN_OUT_BIT];
      if (osc_code == 4'h0) oscillator_output_q <= 1'b0;
      else if (osc_code == 4'hF) oscillator_output_q <= clock_cfg_q[`LPD_CLK_GPO_BIT];
      else oscillator_output_q <= osc_tgl_q;
    end
  end

  // ----------------------------------------------------------------
  // Per-pin drivers
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NPIN; g++) begin : g_chan
    lpd_led_chan #(
      .BLINK(1'b1),
      .FADE(g != 0)
    ) u_chan (
      .clk(clk),
      .reset(reset),
      .restart(sync_clr),
      .period_end(period_end),
      .run(shared_led_clock_on && led_en_q[g] && !data_q[g]),
      .ton(ton_q[g]),
      .ion(ion_q[g]),
      .off_set(off_q[g]),
      .trise(trise_q[g]),
      .tfall(tfall_q[g]),
      .level_q(level[g])
    );
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pwm_q <= 4'h0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        // Only fade-capable pins follow the curve selection
        if (i != 0 && misc_q[`LPD_MISC_LOG_BIT]) pwm_q[i] <= LOG_TBL[level[i][7:1]] > pwm_cnt_q;
        else pwm_q[i] <= level[i] > pwm_cnt_q;
      end
    end
  end

  // LED sinks current, so a lit phase drives the pin low; polarity is not applied to it
  always_ff @(posedge clk) begin
    if (reset) begin
      io_out_q <= 4'h0;
      io_oe_q <= 4'h0;
    end else begin
      for (int i = 0; i < NPIN; i++) begin
        if (shared_led_clock_on && led_en_q[i]) begin
          io_out_q[i] <= !pwm_q[i];
          io_oe_q[i] <= !direction_q[i] && !(open_drain_q[i] && !pwm_q[i] == 1'b1);
        end else begin
          io_out_q[i] <= data_q[i] ^ polarity_q[i];
          io_oe_q[i] <= !direction_q[i] && !(open_drain_q[i] && (data_q[i] ^ polarity_q[i]));
        end
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign io_out = io_out_q;
  assign io_oe = io_oe_q;
  assign oscillator_output = oscillator_output_q;
  assign oscillator_oe = oscillator_oe_q;
endmodule : lpd_led_driver

// ===== src/lpd_map.svh
`ifndef LPD_MAP_SVH
`define LPD_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LPD_IDX_INBUF_OFF 8'h00
`define LPD_IDX_OPEN_DRAIN 8'h05
`define LPD_IDX_POLARITY 8'h06
`define LPD_IDX_DIRECTION 8'h07
`define LPD_IDX_DATA 8'h08
`define LPD_IDX_CLOCK 8'h0D
`define LPD_IDX_MISC 8'h0E
`define LPD_IDX_LED_EN 8'h0F
`define LPD_IDX_PIN0 8'h12
`define LPD_IDX_PIN1 8'h15
`define LPD_PIN_STRIDE 8'h05
`define LPD_IDX_STATUS 8'h30

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LPD_MISC_SHARED_LED_CLOCK_HI 6
`define LPD_MISC_SHARED_LED_CLOCK_LO 4
`define LPD_MISC_LOG_BIT 3
`define LPD_MISC_NRST_BIT 2
`define LPD_CLK_GPO_BIT 7
`define LPD_CLK_SRC_HI 6
`define LPD_CLK_SRC_LO 5
`define LPD_CLK_PIN_OUT_BIT 4
`define LPD_SRC_EXT 2'h1
`define LPD_SRC_INT 2'h2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LPD_RST_ZERO 8'h00
`define LPD_RST_ION 8'hFF
`define LPD_RST_DIR 4'hF
`define LPD_RST_DATA 4'hF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LPD_CLK_HZ 250000000
`define LPD_INT_OSC_HZ 2000000
`define LPD_INT_OSC_DIV (`LPD_CLK_HZ / `LPD_INT_OSC_HZ)

`endif

// ===== src/lpd_pkg.sv
package lpd_pkg;
  typedef logic [7:0] lpd_byte_t;
  typedef enum logic [2:0] {PH_IDLE, PH_RISE, PH_ON, PH_FALL, PH_OFF, PH_DONE} lpd_phase_t;
endpackage : lpd_pkg

// ===== test/lpd_led_model.sv
`timescale 1ns/1ps
module lpd_led_model (
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  output logic [3:0] io_in,
  output logic [3:0] lit
);
  // ----------------------------------------
  // LED to supply on each pin
  // ----------------------------------------
  // The LED pulls an undriven pin up; current flows only while the pin sinks
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_in[i] = io_oe[i] ? io_out[i] : 1'b1;
      lit[i] = io_oe[i] && !io_out[i];
    end
  end
endmodule : lpd_led_model

// ===== test/lpd_monitor.sv
`timescale 1ns/1ps
module lpd_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [3:0] io_oe,
  input wire logic oscillator_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic taken;
  assign taken = hsel && htrans[1] && hready;
  // ----------------------------------------
  // Bus and pin checks
  // ----------------------------------------
  okay_resp_a: assert property (hresp == 1'b0) else $error("response not okay");
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  write_ready_a: assert property (taken && hwrite |=> hreadyout) else $error("write stalled");
  single_wait_a: assert property (!hreadyout |=> hreadyout) else $error("wait state too long");
  rdata_hold_a: assert property (!$rose(hreadyout) |-> $stable(hrdata)) else $error("read data moved");
  rdata_width_a: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
  // Pins stay undriven until software configures them
  reset_quiet_a: assert property ($fell(reset) |-> (io_oe == 4'h0)[*8]) else $error("pin driven after reset");
  osc_quiet_a: assert property ($fell(reset) |-> (!oscillator_oe)[*8]) else $error("osc pin driven");
  read_seen_c: cover property (taken && !hwrite);
  write_seen_c: cover property (taken && hwrite);
  led_drive_c: cover property (io_oe != 4'h0);
endmodule : lpd_monitor

bind lpd_led_driver lpd_monitor mon (.clk(clk), .reset(reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .io_oe(io_oe),
  .oscillator_oe(oscillator_oe));

// ===== test/tb.sv
`timescale 1ns/1ps
`include "lpd_map.svh"
module tb;
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0, osc_in = 0, osc_run = 0, ext_rst_n = 1;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'b010;
  wire hreadyout, hresp, osc_out, osc_oe;
  wire [31:0] hrdata;
  wire [3:0] io_out, io_oe, io_in, lit;
  int bad_count = 0, compares = 0, on_p, off_p;
  int cnt[4];
  always #2 clk = ~clk;
  // External oscillator: one main tick every 2 clk keeps a PWM period at 512 clk
  always @(posedge clk) if (osc_run) osc_in <= ~osc_in;
  lpd_led_driver dut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .oscillator_input(osc_in), .oscillator_output(osc_out),
    .oscillator_oe(osc_oe), .external_reset_pin_n(ext_rst_n));
  lpd_led_model led (.io_out(io_out), .io_oe(io_oe), .io_in(io_in), .lit(lit));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task tally_and_finish;
    if (bad_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task chk_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("mismatch at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_rng
  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 200);
    if (n >= 200) begin
      bad_count++;
      $display("mismatch at %0t: bus timeout", $time);
      tally_and_finish;
    end
  endtask : wait_ready
  task xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_ready;
    rd = hrdata;
  endtask : xfer
  task wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask : wr
  task rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rd_chk
  task measure(input int cyc);
    cnt = '{0, 0, 0, 0};
    repeat (cyc) begin
      @(posedge clk);
      for (int i = 0; i < 4; i++)
        if (lit[i] === 1'b1) cnt[i]++;
    end
  endtask : measure
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("mismatch at %0t: run timeout", $time);
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    rd_chk(`LPD_IDX_PIN0 + 8'h01, 8'hFF);
    rd_chk(`LPD_IDX_DIRECTION, 8'h0F);
    rd_chk(`LPD_IDX_MISC, 8'h00);
    rd_chk(`LPD_IDX_PIN1 + 8'h03, 8'h00);
    rd_chk(8'h7F, 8'h00);
    rd_chk(`LPD_IDX_STATUS, 8'h00);
    // Bring-up order: pins, oscillator, LED clock, enables, levels, then start
    wr(`LPD_IDX_INBUF_OFF, 8'h0F);
    wr(`LPD_IDX_OPEN_DRAIN, 8'h0F);
    wr(`LPD_IDX_DIRECTION, 8'h00);
    wr(`LPD_IDX_CLOCK, 8'h20);
    osc_run <= 1'b1;
    wr(`LPD_IDX_MISC, 8'h10);
    wr(`LPD_IDX_LED_EN, 8'h0F);
    wr(`LPD_IDX_PIN0 + 8'h01, 8'h80);
    xfer(1'b0, `LPD_IDX_STATUS, 8'h00);
    chk(rd & 32'h0000_0030, 32'h0000_0030);
    wr(`LPD_IDX_POLARITY, 8'h02);
    rd_chk(`LPD_IDX_POLARITY, 8'h02);
    wr(`LPD_IDX_POLARITY, 8'h00);
    wr(`LPD_IDX_DATA, 8'h0E);
    // Level moves only at period ends, so allow two periods and the output pipeline
    repeat (1040) @(posedge clk);
    measure(1024);
    chk_rng(cnt[0], 500, 524);
    chk_rng(cnt[1], 0, 0);
    wr(`LPD_IDX_PIN1 + 8'h01, 8'h80);
    wr(`LPD_IDX_MISC, 8'h18);
    wr(`LPD_IDX_DATA, 8'h0C);
    repeat (1040) @(posedge clk);
    measure(1024);
    chk_rng(cnt[1], 204, 220);
    chk_rng(cnt[0], 500, 524);
    wr(`LPD_IDX_DATA, 8'h0F);
    repeat (1040) @(posedge clk);
    measure(1024);
    chk_rng(cnt[0] + cnt[1], 0, 0);
    wr(`LPD_IDX_PIN0 + 8'h01, 8'hFF);
    wr(`LPD_IDX_PIN0, 8'h02);
    wr(`LPD_IDX_DATA, 8'h0E);
    repeat (1040) @(posedge clk);
    measure(1024);
    chk_rng(cnt[0], 1000, 1024);
    repeat (6144) @(posedge clk);
    measure(2048);
    chk_rng(cnt[0], 0, 0);
    wr(`LPD_IDX_DATA, 8'h0F);
    // Data high must span a period end, or the finished shot never returns to idle
    repeat (520) @(posedge clk);
    wr(`LPD_IDX_PIN0 + 8'h02, 8'h10);
    wr(`LPD_IDX_DATA, 8'h0E);
    on_p = 0;
    off_p = 0;
    repeat (14) begin
      measure(1024);
      if (cnt[0] >= 1000) on_p++;
      if (cnt[0] == 0) off_p++;
    end
    chk_rng(on_p, 3, 9);
    chk_rng(off_p, 3, 9);
    wr(`LPD_IDX_MISC, 8'h14);
    ext_rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    ext_rst_n <= 1'b1;
    // Sequencer restarts from idle: dark between the first and second period end
    repeat (530) @(posedge clk);
    measure(480);
    chk_rng(cnt[0], 0, 0);
    rd_chk(`LPD_IDX_PIN0 + 8'h02, 8'h10);
    rd_chk(`LPD_IDX_MISC, 8'h14);
    wr(`LPD_IDX_CLOCK, 8'hBF);
    repeat (4) @(posedge clk);
    chk({30'h0, osc_oe, osc_out}, 32'h0000_0003);
    wr(`LPD_IDX_CLOCK, 8'h3F);
    repeat (4) @(posedge clk);
    chk({30'h0, osc_oe, osc_out}, 32'h0000_0002);
    tally_and_finish;
  end
endmodule : tb
